//--- design/bplc_pkg.sv
package bplc_pkg;
    // byte and word geometry
    localparam int BYTE_W = 8;
    localparam int LANES_PER_GROUP = 4;
    localparam int GROUP_W = 32;
    localparam int WIDE_W = 64;
    // count parameter: low byte of each 32-bit half carries the count
    localparam int COUNT_W = 8;
    localparam int COUNT_LO_POS = 0;
    localparam int COUNT_HI_POS = 32;
    // word counter wide enough to tell a full burst from a short one
    localparam int WORDS_W = 9;
    localparam logic [8:0] FULL_BURST_WORDS = 9'h100;
    localparam logic [8:0] WORDS_RESET = 9'h000;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // connection field geometry
    localparam int IFIELD_W = 32;
    localparam int IFIELD_ADDR_W = 24;
    localparam int IFIELD_SAMPLES = 3;
    localparam logic [1:0] SAMPLE_RESET = 2'h0;

    // destination connection states, one-hot
    typedef enum logic [3:0] {
        BPLC_IDLE = 4'h1,
        BPLC_SAMPLE = 4'h2,
        BPLC_CONN = 4'h4,
        BPLC_REFUSE = 4'h8
    } bplc_dst_state_t;
endpackage : bplc_pkg

//--- design/bplc_byte_parity.sv
`timescale 1ns/10ps
`default_nettype none
// odd parity per byte lane: lane n covers bits 8n..8n+7
module bplc_byte_parity #(
    parameter int LANES = 4
) (
    // word in
    input wire logic [LANES*8-1:0] data,
    // one odd-parity bit per lane
    output logic [LANES-1:0] parity
);
    genvar n;
    generate
        for (n = 0; n < LANES; n = n + 1) begin : g_lane
            // inverted xor so an all-zero byte yields a one
            assign parity[n] = ~(^data[8*n +: 8]);
        end
    endgenerate
endmodule : bplc_byte_parity
`default_nettype wire

//--- design/bplc_check.sv
// Behaviour
// [RULE1] optionally sample I-Field repeatedly before connecting
// [RULE2] drop connection on unsupported short burst
// [RULE3] low I-Field bits address, high bits control
// [RULE4] received I-Field reported as is, never compared; code compares later samples with the first when ifield_check_en is set
// [RULE5] stream bytes map high lane first per word
// [RULE6] highest signal in lane is byte msb
// [RULE7] parity line n odd over bits 8n..8n+7
// [RULE8] source sends checkword right after last word
// [RULE9] count modulo 256 in low byte, repeated
// [RULE10] 256-word burst gives all-zero count
// [RULE11] checkword bit is xor of column plus count
// [RULE12] checkword gets normal parity, parity not accumulated
// [RULE13] source folds count early or late, destination late
// [RULE14] destination recomputes checkword and compares
// [RULE15] register and counter cleared before each burst
// [RULE16] source counter reaches one on first word
// [RULE17] preload mode sends register straight out
// [RULE18] works for 32-bit and 64-bit buses
// [RULE19] destination accumulates checkword, counter holds
// [RULE20] nonzero result after checkword flags error
// [RULE21] one-cycle error flag, state cleared after
// [RULE22] accumulate only on qualified burst words
`timescale 1ns/10ps
`default_nettype none
module bplc_check #(
    parameter int DATA_W = 32
) (
    // system clock and reset
    input wire logic clk,
    input wire logic reset,
    // source user side, byte i of the stream at bits 8i+7..8i
    input wire logic [DATA_W-1:0] src_bytes,
    input wire logic src_valid,
    input wire logic src_last,
    input wire logic src_len_known,
    input wire logic [7:0] src_len,
    output logic src_ready,
    // source cable side, on clk
    output logic [DATA_W-1:0] tx_data,
    output logic [DATA_W/8-1:0] tx_parity,
    output logic tx_burst,
    output logic tx_llrc,
    // destination configuration, quasi-static, clk domain
    input wire logic short_ok,
    input wire logic ifield_check_en,
    // destination events toward system side
    output logic dst_error,
    output logic dst_connected,
    // destination cable side, on the link clock
    input wire logic link_clk,
    input wire logic rx_request,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic [DATA_W/8-1:0] rx_parity,
    input wire logic rx_burst,
    output logic rx_connect,
    // destination user side, link clock
    output logic [DATA_W-1:0] dst_bytes,
    output logic dst_valid,
    output logic [bplc_pkg::IFIELD_ADDR_W-1:0] ifield_addr,
    output logic [bplc_pkg::IFIELD_W-bplc_pkg::IFIELD_ADDR_W-1:0] ifield_ctrl
);
    localparam int NB = DATA_W / 8;

    // count parameter word; second half only exists on the wide bus
    function automatic logic [DATA_W-1:0] count_word(input logic [7:0] c);
        logic [DATA_W-1:0] w;
        w = '0;
        w[bplc_pkg::COUNT_LO_POS +: bplc_pkg::COUNT_W] = c; // see [RULE9]
        if (DATA_W == bplc_pkg::WIDE_W) begin
            w[bplc_pkg::COUNT_HI_POS +: bplc_pkg::COUNT_W] = c; // see [RULE18]
        end
        return w;
    endfunction : count_word

    // stream byte i to lane: groups of four, first byte highest lane
    logic [DATA_W-1:0] src_word;
    logic [DATA_W-1:0] rx_stream;
    genvar i;
    generate
        for (i = 0; i < NB; i = i + 1) begin : g_map
            localparam int LANE = (i / 4) * 4 + 3 - (i % 4);
            // bits copied in order so msb stays on top signal
            assign src_word[8*LANE +: 8] = src_bytes[8*i +: 8]; // see [RULE5]
            assign rx_stream[8*i +: 8] = rx_data[8*LANE +: 8]; // see [RULE6]
        end
    endgenerate

    // ---------------- source, system clock ----------------
    logic src_in_burst;
    logic src_pre;
    logic llrc_due;
    logic [7:0] src_count;
    logic [DATA_W-1:0] src_acc;
    logic [DATA_W-1:0] next_tx_data;
    logic [NB-1:0] next_tx_parity;

    // no word may be taken in the checkword slot
    assign src_ready = ~llrc_due;

    // value placed on the bus next cycle
    always_comb begin
        next_tx_data = '0;
        if (llrc_due) begin
            if (src_pre) begin
                next_tx_data = src_acc; // see [RULE17]
            end else begin
                next_tx_data = src_acc ^ count_word(src_count); // see [RULE13]
            end
        end else if (src_valid) begin
            next_tx_data = src_word;
        end
    end

    bplc_byte_parity #(
        .LANES(NB)
    ) u_tx_par (
        .data(next_tx_data),
        .parity(next_tx_parity)
    );

    // cable outputs, parity taken from the very word being sent
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_data <= '0;
            tx_parity <= '0;
            tx_burst <= 1'b0;
            tx_llrc <= 1'b0;
        end else begin
            tx_data <= next_tx_data;
            tx_parity <= next_tx_parity; // see [RULE7] see [RULE12]
            tx_burst <= src_valid & ~llrc_due;
            tx_llrc <= llrc_due; // see [RULE8]
        end
    end

    // accumulator and word count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            src_acc <= '0;
            src_count <= bplc_pkg::COUNT_RESET;
            src_in_burst <= 1'b0;
            src_pre <= 1'b0;
            llrc_due <= 1'b0;
        end else if (llrc_due) begin
            // cleared here so the next burst starts from zero
            src_acc <= '0; // see [RULE15]
            src_count <= bplc_pkg::COUNT_RESET;
            src_pre <= 1'b0;
            llrc_due <= 1'b0;
        end else if (src_valid) begin
            if (!src_in_burst) begin
                src_count <= 8'h01; // see [RULE16]
                src_pre <= src_len_known;
                // early fold: register preloaded with the known count
                if (src_len_known) begin
                    src_acc <= src_word ^ count_word(src_len); // see [RULE13]
                end else begin
                    src_acc <= src_word;
                end
            end else begin
                src_count <= src_count + 8'h01; // wraps, see [RULE10]
                src_acc <= src_acc ^ src_word; // see [RULE11]
            end
            src_in_burst <= ~src_last;
            llrc_due <= src_last; // see [RULE8]
        end
    end

    // ---------------- destination, link clock ----------------
    // configuration levels enter the link domain through two stages
    logic short_ok_s1;
    logic short_ok_s2;
    logic check_en_s1;
    logic check_en_s2;
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            short_ok_s1 <= 1'b0;
            short_ok_s2 <= 1'b0;
            check_en_s1 <= 1'b0;
            check_en_s2 <= 1'b0;
        end else begin
            short_ok_s1 <= short_ok;
            short_ok_s2 <= short_ok_s1;
            check_en_s1 <= ifield_check_en;
            check_en_s2 <= check_en_s1;
        end
    end

    bplc_pkg::bplc_dst_state_t state;
    logic [1:0] samp_cnt;
    logic [bplc_pkg::IFIELD_W-1:0] ifield;
    logic rx_burst_d;
    logic [bplc_pkg::WORDS_W-1:0] rx_words;
    logic [DATA_W-1:0] rx_acc;
    logic [DATA_W-1:0] syndrome;
    logic [NB-1:0] rx_par_calc;
    logic llrc_slot;
    logic par_bad;
    logic sum_bad;
    logic short_bad;
    logic err_toggle;

    // the cycle after the qualifier falls carries the checkword
    assign llrc_slot = rx_burst_d & ~rx_burst;

    bplc_byte_parity #(
        .LANES(NB)
    ) u_rx_par (
        .data(rx_data),
        .parity(rx_par_calc)
    );

    // checks; count folded in only now since length is unknown earlier
    assign syndrome = rx_acc ^ rx_data ^ count_word(rx_words[7:0]); // see [RULE14]
    assign sum_bad = llrc_slot & (|syndrome); // see [RULE20]
    assign par_bad = (rx_burst | llrc_slot) & (rx_par_calc != rx_parity); // see [RULE7]
    assign short_bad = llrc_slot & ~short_ok_s2 &
                       (rx_words != bplc_pkg::FULL_BURST_WORDS);

    // connection handling
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            state <= bplc_pkg::BPLC_IDLE;
            samp_cnt <= bplc_pkg::SAMPLE_RESET;
            ifield <= '0;
            rx_connect <= 1'b0;
        end else begin
            case (state)
                bplc_pkg::BPLC_IDLE: begin
                    if (rx_request) begin
                        // field taken as seen; a switch may have rewritten it
                        ifield <= rx_data[bplc_pkg::IFIELD_W-1:0]; // see [RULE4]
                        samp_cnt <= 2'h1;
                        if (check_en_s2) begin
                            state <= bplc_pkg::BPLC_SAMPLE;
                        end else begin
                            state <= bplc_pkg::BPLC_CONN;
                            rx_connect <= 1'b1;
                        end
                    end
                end
                bplc_pkg::BPLC_SAMPLE: begin
                    if (!rx_request) begin
                        state <= bplc_pkg::BPLC_IDLE;
                    end else if (rx_data[bplc_pkg::IFIELD_W-1:0] != ifield) begin
                        state <= bplc_pkg::BPLC_REFUSE; // see [RULE1]
                    end else if (samp_cnt == 2'(bplc_pkg::IFIELD_SAMPLES - 1)) begin
                        state <= bplc_pkg::BPLC_CONN;
                        rx_connect <= 1'b1; // see [RULE1]
                    end else begin
                        samp_cnt <= samp_cnt + 2'h1;
                    end
                end
                bplc_pkg::BPLC_CONN: begin
                    if (!rx_request) begin
                        state <= bplc_pkg::BPLC_IDLE;
                        rx_connect <= 1'b0;
                    end else if (short_bad) begin
                        // too short for this receiver: break the connection
                        state <= bplc_pkg::BPLC_REFUSE; // see [RULE2]
                        rx_connect <= 1'b0;
                    end
                end
                bplc_pkg::BPLC_REFUSE: begin
                    // wait for the source to withdraw before a new try
                    rx_connect <= 1'b0;
                    if (!rx_request) begin
                        state <= bplc_pkg::BPLC_IDLE;
                    end
                end
                default: begin
                    state <= bplc_pkg::BPLC_IDLE;
                    rx_connect <= 1'b0;
                end
            endcase
        end
    end

    // low bits address, high bits physical-layer control
    assign ifield_addr = ifield[bplc_pkg::IFIELD_ADDR_W-1:0]; // see [RULE3]
    assign ifield_ctrl = ifield[bplc_pkg::IFIELD_W-1:bplc_pkg::IFIELD_ADDR_W];

    // receive accumulation; parity bits never enter the sum
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            rx_burst_d <= 1'b0;
            rx_acc <= '0;
            rx_words <= bplc_pkg::WORDS_RESET;
        end else begin
            rx_burst_d <= rx_burst;
            if (llrc_slot) begin
                // checkword absorbed into the syndrome, then both cleared
                rx_acc <= '0; // see [RULE19] see [RULE15]
                rx_words <= bplc_pkg::WORDS_RESET;
            end else if (rx_burst) begin
                rx_acc <= rx_acc ^ rx_data; // see [RULE22] see [RULE12]
                if (rx_words != bplc_pkg::FULL_BURST_WORDS) begin
                    rx_words <= rx_words + 9'h001;
                end
            end
        end
    end

    // received stream and error event toward the system domain
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            dst_bytes <= '0;
            dst_valid <= 1'b0;
            err_toggle <= 1'b0;
        end else begin
            dst_bytes <= rx_stream;
            dst_valid <= rx_burst;
            if (sum_bad | par_bad) begin
                err_toggle <= ~err_toggle; // see [RULE21]
            end
        end
    end

    // error toggle crossing, one system pulse per link event; connect level through two stages
    logic err_s1;
    logic err_s2;
    logic err_s3;
    logic conn_s1;
    logic conn_s2;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            err_s1 <= 1'b0;
            err_s2 <= 1'b0;
            err_s3 <= 1'b0;
            conn_s1 <= 1'b0;
            conn_s2 <= 1'b0;
            dst_error <= 1'b0;
        end else begin
            err_s1 <= err_toggle;
            err_s2 <= err_s1;
            err_s3 <= err_s2;
            conn_s1 <= rx_connect;
            conn_s2 <= conn_s1;
            dst_error <= err_s2 ^ err_s3; // see [RULE21]
        end
    end
    assign dst_connected = conn_s2;
endmodule : bplc_check
`default_nettype wire

//--- bench/bplc_check_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// watches the block's ports in both clock domains
module bplc_check_monitor #(
    parameter int DATA_W = 32
) (
    // clocks and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic link_clk,
    // source side
    input wire logic src_valid,
    input wire logic src_last,
    input wire logic src_ready,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic [DATA_W/8-1:0] tx_parity,
    input wire logic tx_burst,
    input wire logic tx_llrc,
    // destination side
    input wire logic rx_request,
    input wire logic rx_burst,
    input wire logic rx_connect,
    input wire logic dst_valid,
    input wire logic dst_error
);
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] cword;
    logic [7:0] cnt;
    // own copy of the checkword, restarted after each one is sent
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc <= '0;
            cnt <= 8'h00;
        end else if (tx_llrc) begin
            acc <= '0;
            cnt <= 8'h00;
        end else if (tx_burst) begin
            acc <= acc ^ tx_data;
            cnt <= cnt + 8'h01; // wraps, so 256 words give zero
        end
    end
    // count sits in the low byte of every 32-bit half
    always_comb begin
        cword = '0;
        for (int i = 0; i < DATA_W / 32; i++) cword[32*i+:8] = cnt;
    end
    function automatic logic [DATA_W/8-1:0] oddp(input logic [DATA_W-1:0] d);
        for (int i = 0; i < DATA_W / 8; i++) oddp[i] = ~^d[8*i+:8];
    endfunction : oddp
    llrc_slot_a: assert property (
        @(posedge clk) disable iff (reset)
        src_valid && src_ready && src_last |-> ##2 tx_llrc && !tx_burst)
        else $error("checkword slot missed");
    ready_gap_a: assert property (
        @(posedge clk) disable iff (reset)
        src_valid && src_ready && src_last |=> !src_ready)
        else $error("no gap after last word");
    burst_take_a: assert property (
        @(posedge clk) disable iff (reset)
        src_valid && src_ready |=> tx_burst)
        else $error("taken word not sent");
    burst_none_a: assert property (
        @(posedge clk) disable iff (reset)
        !(src_valid && src_ready) |=> !tx_burst)
        else $error("word sent without request");
    tx_parity_a: assert property (
        @(posedge clk) disable iff (reset)
        tx_burst || tx_llrc |-> tx_parity == oddp(tx_data))
        else $error("bad byte parity");
    llrc_value_a: assert property (
        @(posedge clk) disable iff (reset)
        tx_llrc |-> tx_data == (acc ^ cword))
        else $error("bad checkword");
    err_pulse_a: assert property (
        @(posedge clk) disable iff (reset)
        dst_error |=> !dst_error)
        else $error("error flag too long");
    valid_delay_a: assert property (
        @(posedge link_clk) disable iff (reset)
        rx_burst |=> dst_valid)
        else $error("received word not passed on");
    drop_req_a: assert property (
        @(posedge link_clk) disable iff (reset)
        !rx_request |=> !rx_connect)
        else $error("connect without request");
endmodule : bplc_check_monitor
bind bplc_check bplc_check_monitor #(.DATA_W(DATA_W)) bplc_check_monitor_inst (
    .clk, .reset, .link_clk, .src_valid, .src_last, .src_ready, .tx_data,
    .tx_parity, .tx_burst, .tx_llrc, .rx_request, .rx_burst, .rx_connect,
    .dst_valid, .dst_error);
`default_nettype wire

//--- bench/bplc_far_src.sv
`timescale 1ns/10ps
`default_nettype none
// remote source across the cable, paced by the link clock
module bplc_far_src (
    // link clock
    input wire logic link_clk,
    // cable toward the block
    output logic rx_request,
    output logic [31:0] rx_data,
    output logic [3:0] rx_parity,
    output logic rx_burst
);
    // idle cable at time zero
    initial begin
        rx_request = 1'b0;
        rx_data = 32'h0000_0000;
        rx_parity = 4'hF;
        rx_burst = 1'b0;
    end
    // one word per link edge; bp spoils lane 0 parity
    task automatic put(input logic [31:0] d, input logic b, input logic bp);
        @(posedge link_clk);
        rx_data <= d;
        rx_parity <= {3'h0, bp} ^ {~^d[31:24], ~^d[23:16], ~^d[15:8],
                                   ~^d[7:0]};
        rx_burst <= b;
    endtask : put
    // address in the low bits; alt spoils the middle sample
    task automatic connect(input logic [31:0] f, input logic alt);
        put(f, 1'b0, 1'b0);
        rx_request <= 1'b1;
        put(alt ? ~f : f, 1'b0, 1'b0);
        put(f, 1'b0, 1'b0);
        put(~f, 1'b0, 1'b0); // released bus shows the inverse
        @(posedge link_clk);
    endtask : connect
    // burst then checkword; count folded in from the start
    task automatic burst(input int n, input logic bl, input logic bp);
        logic [31:0] acc;
        logic [31:0] w;
        acc = {24'h00_0000, n[7:0]};
        for (int k = 0; k < n; k++) begin
            w = 32'h1B2C_3D4E ^ (k * 32'h0107_0B0D);
            acc ^= w;
            put(w, 1'b1, 1'b0);
        end
        put(acc ^ {31'h0, bl}, 1'b0, bp);
        put(~acc, 1'b0, 1'b0);
    endtask : burst
    // drop request and let the far end settle
    task automatic hang_up;
        @(posedge link_clk);
        rx_request <= 1'b0;
        repeat (3) @(posedge link_clk);
    endtask : hang_up
endmodule : bplc_far_src
`default_nettype wire

//--- bench/bplc_check_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    n_mismatch++; $display("ERROR %0t value mismatch", $time); end end
module bplc_check_bench;
    logic clk, reset, link_clk, src_valid, src_last, src_len_known;
    logic short_ok, ifield_check_en, src_ready, tx_burst, tx_llrc;
    logic dst_error, dst_connected, rx_request, rx_burst, rx_connect;
    logic dst_valid;
    logic [31:0] src_bytes, tx_data, rx_data, dst_bytes;
    logic [3:0] tx_parity, rx_parity;
    logic [7:0] src_len, ifield_ctrl;
    logic [23:0] ifield_addr;
    int n_mismatch = 0;
    int cmp_count = 0;
    bplc_check #(.DATA_W(32)) bplc_check_inst (.clk, .reset, .src_bytes,
        .src_valid, .src_last, .src_len_known, .src_len, .src_ready, .tx_data,
        .tx_parity, .tx_burst, .tx_llrc, .short_ok, .ifield_check_en,
        .dst_error, .dst_connected, .link_clk, .rx_request, .rx_data,
        .rx_parity, .rx_burst, .rx_connect, .dst_bytes, .dst_valid,
        .ifield_addr, .ifield_ctrl);
    bplc_far_src bplc_far_src_inst (.link_clk, .rx_request, .rx_data,
        .rx_parity, .rx_burst);
    // system clock, then an unrelated link clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #80 link_clk = ~link_clk;
    end
    // stream byte 0 lands on the top lane
    function automatic logic [31:0] swap(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : swap
    function automatic logic [3:0] par(input logic [31:0] d);
        return {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
    endfunction : par
    function automatic logic [31:0] word(input int k);
        return 32'h9E37_79B9 ^ (k * 32'h0103_0507);
    endfunction : word
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // source burst of n words; a refused word is offered in the gap
    task automatic src_test(input int n, input logic pre);
        logic [31:0] acc;
        acc = {24'h00_0000, n[7:0]};
        for (int k = 0; k <= n; k++) begin
            @(posedge clk);
            src_bytes <= word(k);
            src_valid <= 1'b1;
            src_last <= (k == n - 1);
            src_len_known <= pre;
            src_len <= n[7:0];
            if (k > 0) begin
                @(negedge clk);
                `CHK(tx_burst, 1'b1)
                `CHK(tx_data, swap(word(k - 1)))
                `CHK(tx_parity, par(swap(word(k - 1))))
            end
            if (k < n) acc ^= swap(word(k));
        end
        `CHK(src_ready, 1'b0)
        @(posedge clk);
        src_valid <= 1'b0;
        src_last <= 1'b0;
        @(negedge clk);
        `CHK(tx_burst, 1'b0)
        `CHK(tx_llrc, 1'b1)
        `CHK(tx_data, acc)
        `CHK(tx_parity, par(acc))
    endtask : src_test
    // connection attempt; exp says whether it should be accepted
    task automatic dst_conn(input logic [31:0] f, input logic chk,
                            input logic alt, input logic exp);
        @(posedge clk);
        ifield_check_en <= chk;
        repeat (8) @(posedge clk);
        bplc_far_src_inst.connect(f, alt);
        #1;
        `CHK(rx_connect, exp)
        // inverted field left on the bus is passed on but not as a word
        `CHK(dst_valid, 1'b0)
        `CHK(dst_bytes, swap(~f))
        if (exp) begin
            `CHK(ifield_addr, f[23:0])
            `CHK(ifield_ctrl, f[31:24])
        end
        // sampled away from the edge that moves the synchroniser
        repeat (10) @(negedge clk);
        `CHK(dst_connected, exp)
    endtask : dst_conn
    // received burst; ne error pulses expected, negative skips that
    task automatic dst_burst(input int n, input logic bl, input logic bp,
                             input int ne, input logic ec);
        int seen;
        seen = 0;
        fork
            bplc_far_src_inst.burst(n, bl, bp);
            begin
                // first word is taken at the second link edge, out after it
                repeat (2) @(posedge link_clk);
                #1;
                `CHK(dst_valid, 1'b1)
                `CHK(dst_bytes, swap(32'h1B2C_3D4E))
            end
        join
        #1;
        `CHK(rx_connect, ec)
        repeat (20) begin
            @(negedge clk);
            if (dst_error === 1'b1) seen++;
        end
        `CHK(dst_error, 1'b0)
        if (ne >= 0) `CHK(seen, ne)
    endtask : dst_burst
    // main sequence
    initial begin
        reset = 1'b1;
        src_valid = 1'b0;
        src_last = 1'b0;
        src_len_known = 1'b0;
        src_len = 8'h00;
        src_bytes = 32'h0000_0000;
        short_ok = 1'b1;
        ifield_check_en = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        src_test(1, 1'b0);
        src_test(3, 1'b1);
        src_test(2, 1'b0);
        src_test(256, 1'b0);
        dst_conn(32'h5A00_1234, 1'b0, 1'b0, 1'b1);
        dst_burst(4, 1'b0, 1'b0, 0, 1'b1);
        dst_burst(5, 1'b1, 1'b0, 1, 1'b1);
        dst_burst(3, 1'b0, 1'b1, 1, 1'b1);
        dst_burst(1, 1'b0, 1'b0, 0, 1'b1);
        bplc_far_src_inst.hang_up();
        dst_conn(32'hC300_0042, 1'b1, 1'b1, 1'b0);
        bplc_far_src_inst.hang_up();
        dst_conn(32'hC300_0042, 1'b1, 1'b0, 1'b1);
        @(posedge clk);
        short_ok <= 1'b0;
        dst_burst(2, 1'b0, 1'b0, 0, 1'b0);
        test_done();
    end
endmodule : bplc_check_bench
`default_nettype wire
